// >>> verilog/csvcs_pkg.sv
// Shared constants and types for the CSV register command server
package csvcs_pkg;
  localparam int NREG    = 20;           // Numbered registers in the bank
  localparam int MAX_CNT = 20;           // Largest count in one request
  localparam int MAX_FLD = 23;           // Command, start, count and 20 values
  // Command codes and error replies
  localparam logic [31:0] CMD_RD   = 32'h0000_0003;
  localparam logic [31:0] CMD_WR   = 32'h0000_0010;
  localparam logic [31:0] ERR_FLAG = 32'h0000_0080;
  localparam logic [31:0] ERR_FMT  = 32'hffff_ffff; // Data format error
  localparam logic [31:0] ERR_LIM  = 32'hffff_fffe; // Data limit error
  // Characters of the text frame
  localparam logic [7:0] CH_SEMI  = 8'h3b;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  // Register indices
  localparam int R_CTRL  = 0;
  localparam int R_PROG  = 1;
  localparam int R_MODE  = 2;
  localparam int R_TIME  = 3;
  localparam int R_PUNIT = 4;
  localparam int R_PRESS = 5;
  localparam int R_VUNIT = 6;
  localparam int R_VAC   = 7;
  // Control bits of register 0
  localparam int B_TRIG  = 0;
  localparam int B_ESTOP = 1;
  localparam int B_SLEEP = 2;
  localparam int B_DEL0  = 3;
  localparam int B_DATE  = 4;
  localparam int B_PARAM = 5;
  localparam int B_PROG  = 6;
  localparam int B_UNITS = 7;
  localparam int B_DEL1  = 11;
  // Field codes: time in 0.1 ms, pressure and vacuum in hundredths
  localparam logic [31:0] MODE_TIMED    = 32'h0000_0001;
  localparam logic [31:0] MODE_REPEATED = 32'h0000_0004; // repeated_shot_mode
  localparam logic [31:0] UNIT_PSI      = 32'h0000_0000;
  localparam logic [31:0] UNIT_INH2O    = 32'h0000_0000;
  localparam logic [31:0] RST_VAL       = 32'h0000_0000;
  // Active program settings
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] time_tenth_ms;
    logic [31:0] p_unit;
    logic [31:0] pressure;
    logic [31:0] v_unit;
    logic [31:0] vacuum;
  } csvcs_prog_t;
  // One-cycle control events
  typedef struct packed {
    logic trigger;
    logic log_delete;
    logic set_date;
    logic param_update;
    logic prog_update;
    logic units_update;
  } csvcs_evt_t;
endpackage

// >>> verilog/csvcs_server.sv
// CSV register command server: parses frames, checks, replies, applies
// Operation
// - Read count outside 1..20 gives 131,-2
// - Read with missing fields gives 131,-1
// - Error command is received code OR 0x80
// - Read reply echoes request, then ascending values
// - Accepted write echoed back identically
// - Too few write values gives 144,-1
// - Out-of-range value gives 144,-2, mode 1..4
// - Register 1 program, register 2 mode
// - Control value 64 activates register 1 program
// - Same-frame program number is used
// - Control value 32 adopts frame parameters
// - Time 0.1 ms units, pressure hundredths
// - Mode 1 timed, unit codes 0
// - Twenty registers provided, indices 0..19
// - Frames end with semicolon
// - Edge bits act on rising transition
// - Stop and sleep follow bit level
`timescale 1ns/10ps
`default_nettype none
module csvcs_server #(
  parameter int NUM_REGS = csvcs_pkg::NREG  // Registers in the bank
) (
  input  wire logic              ref_clk,     // System clock
  input  wire logic              reset_n,     // Async reset, active low
  input  wire logic [7:0]        rx_data,     // Received character
  input  wire logic              rx_valid,    // Received character present
  output logic                   rx_ready,    // Server takes character
  output logic [7:0]             tx_data,     // Reply character
  output logic                   tx_valid,    // Reply character present
  input  wire logic              tx_ready,    // Client takes character
  output logic [31:0]            active_prog, // Active program number
  output csvcs_pkg::csvcs_prog_t prog,        // Active program settings
  output logic                   estop,       // Emergency stop level
  output logic                   sleep,       // Sleep level
  output csvcs_pkg::csvcs_evt_t  evt          // Control event pulses
);
  typedef enum {S_RX, S_CHK, S_LOAD, S_DIG, S_SEP} csvcs_state_t;

  csvcs_state_t st;                                    // Frame state
  logic [31:0]  fld [csvcs_pkg::MAX_FLD];              // Parsed fields
  logic [31:0]  regs [NUM_REGS];                       // Register bank
  logic [31:0]  next_regs [NUM_REGS];                  // Bank after commit
  logic [4:0]   nf;                                    // Fields parsed
  logic [31:0]  acc;                                   // Digit accumulator
  logic         neg;                                   // Minus seen
  logic         have_dig;                              // Digit seen
  logic         bad;                                   // Malformed text
  logic         next_err;                              // Check outcome
  logic [31:0]  next_code;                             // Error code found
  logic         resp_err;                              // Reply is an error
  logic [31:0]  err_code;                              // Error code held
  logic [4:0]   nout;                                  // Reply fields
  logic [4:0]   oi;                                    // Reply field index
  logic [31:0]  mag;                                   // Magnitude to print
  logic [3:0]   pidx;                                  // Decimal position
  logic [3:0]   dig;                                   // Digit being formed
  logic         started;                               // Leading zeros gone
  logic [31:0]  w;                                     // Reply field value
  logic [31:0]  pw;                                    // Power of ten
  logic         emit;                                  // Byte goes out
  logic [7:0]   emit_byte;                             // Byte value
  logic         step;                                  // Output slot free
  logic         last;                                  // Final reply field
  logic         take;                                  // Character taken
  logic         term;                                  // Separator taken
  logic         commit;                                // Write accepted
  logic [31:0]  rise;                                  // Control bit edges
  logic [31:0]  f_cmd;                                 // Command field
  logic signed [31:0] f_start;                         // Start field
  logic signed [31:0] f_cnt;                           // Count field
  logic [4:0]   rd_idx;                                // Register being read

  assign f_cmd    = fld[0];
  assign f_start  = fld[1];
  assign f_cnt    = fld[2];
  assign rx_ready = (st == S_RX);
  assign take     = rx_valid && rx_ready;
  assign term     = take && (rx_data == csvcs_pkg::CH_COMMA || rx_data == csvcs_pkg::CH_SEMI);
  assign step     = !tx_valid || tx_ready;
  assign last     = (oi == nout - 5'd1);
  assign rd_idx   = 5'(f_start[4:0] + oi - 5'd3);
  assign estop    = regs[csvcs_pkg::R_CTRL][csvcs_pkg::B_ESTOP];
  assign sleep    = regs[csvcs_pkg::R_CTRL][csvcs_pkg::B_SLEEP];

  // Character parser: signed decimals, spaces skipped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nf       <= 5'h00;
      acc      <= 32'h0000_0000;
      neg      <= 1'b0;
      have_dig <= 1'b0;
      bad      <= 1'b0;
      for (int i = 0; i < csvcs_pkg::MAX_FLD; i++) begin
        fld[i] <= 32'h0000_0000;
      end
    end else if (st == S_SEP && step && last) begin
      nf  <= 5'h00; // Next frame starts empty
      bad <= 1'b0;
    end else if (take) begin
      if (rx_data >= csvcs_pkg::CH_ZERO && rx_data <= csvcs_pkg::CH_NINE) begin
        acc      <= 32'(acc * 32'd10 + 32'(rx_data - csvcs_pkg::CH_ZERO));
        have_dig <= 1'b1;
      end else if (rx_data == csvcs_pkg::CH_MINUS && !have_dig && !neg) begin
        neg <= 1'b1;
      end else if (term) begin
        // Field ends at comma or semicolon
        if (have_dig && nf < 5'(csvcs_pkg::MAX_FLD)) begin
          fld[nf] <= neg ? 32'(-acc) : acc;
          nf      <= nf + 5'd1;
        end else begin
          bad <= 1'b1; // Empty field or too many fields
        end
        acc      <= 32'h0000_0000;
        neg      <= 1'b0;
        have_dig <= 1'b0;
      end else if (rx_data != csvcs_pkg::CH_SPACE) begin
        bad <= 1'b1;
      end
    end
  end

  // Frame check: format, then limits, then field count, then mode value
  always_comb begin
    next_err  = 1'b1;
    next_code = csvcs_pkg::ERR_FMT;
    if (bad || nf < 5'd3) begin
      next_code = csvcs_pkg::ERR_FMT;
    end else if (f_cmd != csvcs_pkg::CMD_RD && f_cmd != csvcs_pkg::CMD_WR) begin
      next_code = csvcs_pkg::ERR_FMT;
    end else if (f_cnt < 1 || f_cnt > csvcs_pkg::MAX_CNT) begin
      next_code = csvcs_pkg::ERR_LIM;
    end else if (f_start < 0 || f_start + f_cnt > NUM_REGS) begin
      next_code = csvcs_pkg::ERR_LIM;
    end else if (32'(nf) != ((f_cmd == csvcs_pkg::CMD_RD) ? 32'd3 : 32'(f_cnt + 3))) begin
      next_code = csvcs_pkg::ERR_FMT;
    end else begin
      next_err = 1'b0;
      for (int k = 3; k < csvcs_pkg::MAX_FLD; k++) begin
        // Mode register accepts codes 1..4 only
        if (f_cmd == csvcs_pkg::CMD_WR && k < 32'(nf) && f_start + k - 3 == csvcs_pkg::R_MODE &&
            ($signed(fld[k]) < 1 || $signed(fld[k]) > 4)) begin
          next_err  = 1'b1;
          next_code = csvcs_pkg::ERR_LIM;
        end
      end
    end
  end

  // Bank image after an accepted write
  assign commit = (st == S_CHK) && !next_err && f_cmd == csvcs_pkg::CMD_WR;
  always_comb begin
    for (int r = 0; r < NUM_REGS; r++) begin
      if (commit && r >= f_start && r < f_start + f_cnt) begin
        next_regs[r] = fld[5'(r - f_start + 3)];
      end else begin
        next_regs[r] = regs[r];
      end
    end
  end
  assign rise = next_regs[csvcs_pkg::R_CTRL] & ~regs[csvcs_pkg::R_CTRL];

  // Register bank: whole frame lands in one edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        regs[r] <= csvcs_pkg::RST_VAL;
      end
    end else if (commit) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        regs[r] <= next_regs[r];
      end
    end
  end

  // Program and parameter adoption on control edges
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_prog <= csvcs_pkg::RST_VAL;
      prog        <= '0;
      evt         <= '0;
    end else begin
      evt <= '0;
      if (commit) begin
        evt.trigger    <= rise[csvcs_pkg::B_TRIG];
        evt.set_date   <= rise[csvcs_pkg::B_DATE];
        evt.log_delete <= (rise[csvcs_pkg::B_DEL0] || rise[csvcs_pkg::B_DEL1]) &&
                          next_regs[0][csvcs_pkg::B_DEL0] && next_regs[0][csvcs_pkg::B_DEL1];
        evt.param_update <= rise[csvcs_pkg::B_PARAM];
        evt.prog_update  <= rise[csvcs_pkg::B_PROG] || rise[csvcs_pkg::B_PARAM];
        evt.units_update <= rise[csvcs_pkg::B_UNITS] || rise[csvcs_pkg::B_PARAM];
        if (rise[csvcs_pkg::B_PROG] || rise[csvcs_pkg::B_PARAM]) begin
          active_prog <= next_regs[csvcs_pkg::R_PROG];
        end
        if (rise[csvcs_pkg::B_PARAM]) begin
          // Same-frame parameters become active
          prog.mode          <= next_regs[csvcs_pkg::R_MODE];
          prog.time_tenth_ms <= next_regs[csvcs_pkg::R_TIME];
          prog.pressure      <= next_regs[csvcs_pkg::R_PRESS];
          prog.vacuum        <= next_regs[csvcs_pkg::R_VAC];
        end
        if (rise[csvcs_pkg::B_UNITS] || rise[csvcs_pkg::B_PARAM]) begin
          prog.p_unit <= next_regs[csvcs_pkg::R_PUNIT];
          prog.v_unit <= next_regs[csvcs_pkg::R_VUNIT];
        end
      end
    end
  end

  // Reply field selection
  always_comb begin
    if (resp_err) begin
      w = (oi == 5'd0) ? (f_cmd | csvcs_pkg::ERR_FLAG) : err_code;
    end else if (oi < 5'd3 || f_cmd == csvcs_pkg::CMD_WR) begin
      w = fld[oi];
    end else if (rd_idx == 5'(csvcs_pkg::R_PROG)) begin
      w = active_prog;
    end else if (rd_idx == 5'(csvcs_pkg::R_MODE)) begin
      w = prog.mode;
    end else begin
      w = regs[rd_idx];
    end
  end

  // Powers of ten for digit extraction
  always_comb begin
    pw = 32'd1;
    for (int p = 0; p < 10; p++) begin
      if (4'(p) < pidx) begin
        pw = 32'(pw * 32'd10);
      end
    end
  end

  // Byte to send in this state
  always_comb begin
    emit      = 1'b0;
    emit_byte = csvcs_pkg::CH_ZERO;
    unique case (st)
      S_LOAD: begin
        emit      = w[31];
        emit_byte = csvcs_pkg::CH_MINUS;
      end
      S_DIG: begin
        emit      = (mag < pw) && (started || dig != 4'h0 || pidx == 4'h0);
        emit_byte = 8'(csvcs_pkg::CH_ZERO + 8'(dig));
      end
      S_SEP: begin
        emit      = 1'b1;
        emit_byte = last ? csvcs_pkg::CH_SEMI : csvcs_pkg::CH_COMMA;
      end
      default: begin
        emit = 1'b0;
      end
    endcase
  end

  // Frame sequencer: receive, check, print fields
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st       <= S_RX;
      resp_err <= 1'b0;
      err_code <= 32'h0000_0000;
      nout     <= 5'h00;
      oi       <= 5'h00;
      mag      <= 32'h0000_0000;
      pidx     <= 4'h0;
      dig      <= 4'h0;
      started  <= 1'b0;
    end else begin
      unique case (st)
        S_RX: begin
          if (term && rx_data == csvcs_pkg::CH_SEMI) begin
            st <= S_CHK;
          end
        end
        S_CHK: begin
          resp_err <= next_err;
          err_code <= next_code;
          nout     <= next_err ? 5'd2 : (f_cmd == csvcs_pkg::CMD_RD) ? 5'(f_cnt + 3) : nf;
          oi       <= 5'h00;
          st       <= S_LOAD;
        end
        S_LOAD: begin
          if (step) begin
            mag     <= w[31] ? 32'(-w) : w;
            pidx    <= 4'd9;
            dig     <= 4'h0;
            started <= 1'b0;
            st      <= S_DIG;
          end
        end
        S_DIG: begin
          if (step) begin
            if (mag >= pw) begin
              mag <= mag - pw;
              dig <= dig + 4'h1;
            end else begin
              started <= started || dig != 4'h0;
              dig     <= 4'h0;
              if (pidx == 4'h0) begin
                st <= S_SEP;
              end else begin
                pidx <= pidx - 4'h1;
              end
            end
          end
        end
        S_SEP: begin
          if (step) begin
            oi <= oi + 5'd1;
            st <= last ? S_RX : S_LOAD;
          end
        end
      endcase
    end
  end

  // Output byte register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end else if (step) begin
      tx_valid <= emit;
      tx_data  <= emit_byte;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  rd_count_a: assert property ((st == S_CHK && !bad && nf == 5'd3 && f_cmd == csvcs_pkg::CMD_RD && f_cnt > 20) |=> resp_err && err_code == csvcs_pkg::ERR_LIM) else $error("read count not limited");
  rd_format_a: assert property ((st == S_CHK && nf < 5'd3) |=> resp_err && err_code == csvcs_pkg::ERR_FMT) else $error("short read not format error");
  err_cmd_a: assert property ((st == S_LOAD && resp_err && oi == 5'd0) |-> w == (fld[0] | 32'h80)) else $error("error command lacks flag");
  wr_short_a: assert property ((st == S_CHK && !bad && f_cmd == csvcs_pkg::CMD_WR && f_cnt >= 1 && f_cnt <= 20 && f_start >= 0 && f_start + f_cnt <= NUM_REGS && 32'(nf) < f_cnt + 3) |=> resp_err && err_code == csvcs_pkg::ERR_FMT && $stable(regs[0])) else $error("short write applied");
  mode_range_a: assert property ((commit && f_start <= 2 && f_start + f_cnt > 2) |=> $signed(regs[2]) >= 1 && $signed(regs[2]) <= 4) else $error("mode out of range stored");
  prog_sel_a: assert property ((commit && rise[6]) |=> active_prog == $past(next_regs[1])) else $error("program not activated");
  trig_edge_a: assert property (evt.trigger |-> regs[0][0] && $past(commit)) else $error("trigger without rising bit");
  level_bits_a: assert property ($rose(estop) |-> $past(commit) && regs[0][1]) else $error("stop level without write");
  frame_end_a: assert property ((st == S_SEP && step && last) |=> tx_valid && tx_data == 8'h3b && st == S_RX) else $error("reply not ended by semicolon");
endmodule
`default_nettype wire

// >>> bench/csvcs_client.sv
// Client model: sends text frames and collects reply characters
`timescale 1ns/10ps
`default_nettype none
module csvcs_client (
  input  wire logic       ref_clk,  // System clock
  output logic [7:0]      rx_data,  // Character to server
  output logic            rx_valid, // Character present
  input  wire logic       rx_ready, // Server takes character
  input  wire logic [7:0] tx_data,  // Reply character
  input  wire logic       tx_valid, // Reply character present
  output logic            tx_ready  // Reply character taken
);
  bit slow = 1'b0; // Toggle reply ready every cycle until the semicolon
  // Idle link at time zero
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // Send one frame, character held until an accepting edge
  task automatic send(input string s);
    bit ok;
    for (int i = 0; i < s.len(); i++) begin
      rx_data <= s[i];
      rx_valid <= 1'b1;
      do begin
        @(negedge ref_clk);
        ok = rx_ready;
        @(posedge ref_clk);
      end while (!ok);
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data; // Released line shows no stale character
  endtask
  // Collect reply bytes up to the closing semicolon
  task automatic recv(output logic [1023:0] r);
    bit v;
    logic [7:0] d;
    bit done;
    int n;
    r = '0;
    done = 1'b0;
    n = 0;
    tx_ready <= 1'b1;
    while (!done && n < 4000) begin
      @(negedge ref_clk);
      v = tx_valid & tx_ready;
      d = tx_data;
      @(posedge ref_clk);
      n++;
      if (v) begin
        r = {r[1015:0], d};
        done = (d == 8'h3b);
      end
      if (done) begin
        tx_ready <= 1'b0;
      end else begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/csv_register_command_server_tb_top.sv
// Self-checking bench for the CSV register command server
`timescale 1ns/10ps
`default_nettype none
module csv_register_command_server_tb_top;
  logic                   ref_clk = 1'b0;  // System clock
  logic                   reset_n = 1'b0;  // Async reset, active low
  logic [7:0]             rx_data;         // Character to server
  logic                   rx_valid;        // Character present
  logic                   rx_ready;        // Server takes character
  logic [7:0]             tx_data;         // Reply character
  logic                   tx_valid;        // Reply present
  logic                   tx_ready;        // Reply taken
  logic [31:0]            active_prog;     // Active program
  csvcs_pkg::csvcs_prog_t prog;            // Active settings
  logic                   estop;           // Stop level
  logic                   sleep;           // Sleep level
  csvcs_pkg::csvcs_evt_t  evt;             // Event pulses
  int                     errors = 0;      // Mismatches
  int                     n_compared = 0;  // Comparisons made
  int                     cycles = 0;      // Timeout counter
  int                     cnt [6];         // Pulses per event bit
  // Clock at 100 MHz
  always #5 ref_clk = ~ref_clk;
  csvcs_server dut (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .rx_data     (rx_data),
    .rx_valid    (rx_valid),
    .rx_ready    (rx_ready),
    .tx_data     (tx_data),
    .tx_valid    (tx_valid),
    .tx_ready    (tx_ready),
    .active_prog (active_prog),
    .prog        (prog),
    .estop       (estop),
    .sleep       (sleep),
    .evt         (evt)
  );
  csvcs_client client (
    .ref_clk  (ref_clk),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .rx_ready (rx_ready),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready)
  );
  // Count event pulses and cut a hang short
  always @(posedge ref_clk) begin
    for (int k = 0; k < 6; k++) begin
      if (evt[k] === 1'b1) begin
        cnt[k]++;
      end
    end
    cycles++;
    if (cycles == 60000) begin
      errors++;
      final_report();
    end
  end
  // Print verdict and stop
  task automatic final_report();
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compare a whole reply frame
  task automatic cmp_reply(input logic [1023:0] e, input logic [1023:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Compare a port or counter value
  task automatic cmp_val(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // One request and its checked reply; polls back to back
  task automatic xact(input string req, input logic [1023:0] exp);
    logic [1023:0] got;
    client.send(req);
    client.recv(got);
    cmp_reply(exp, got);
  endtask
  // Main sequence
  initial begin
    foreach (cnt[k]) cnt[k] = 0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    cmp_val(32'h0000_0001, {31'h0, rx_ready});
    cmp_val(32'h0000_0000, active_prog);
    // Malformed and out-of-limit requests, then one valid read
    xact("3, 0;", "131,-1;");
    xact("3, 0, 21;", "131,-2;");
    xact("3,0,0;", "131,-2;");
    xact("5,0,1;", "133,-1;");
    xact("16,0,5,0,1,1;", "144,-1;");
    xact("16,1,5,1,6,150,0,5600;", "144,-2;");
    xact("16,19,2,1,2;", "144,-2;");
    xact("3,3,3;", "3,3,3,0,0,0;");
    // Plain write then read back
    xact("16, 1, 5, 1, 1, 150, 0, 5600;", "16,1,5,1,1,150,0,5600;");
    xact("3,1,5;", "3,1,5,0,0,150,0,5600;");
    // Parameter update with stalled reply
    client.slow = 1'b1;
    xact("16,0,8,32,15,1,1500,0,1475,0,600;", "16,0,8,32,15,1,1500,0,1475,0,600;");
    client.slow = 1'b0;
    cmp_val(32'h0000_000f, active_prog);
    cmp_val(csvcs_pkg::MODE_TIMED, prog.mode);
    cmp_val(32'h0000_05dc, prog.time_tenth_ms);
    cmp_val(csvcs_pkg::UNIT_PSI, prog.p_unit);
    cmp_val(32'h0000_05c3, prog.pressure);
    cmp_val(csvcs_pkg::UNIT_INH2O, prog.v_unit);
    cmp_val(32'h0000_0258, prog.vacuum);
    xact("16,0,1,0;", "16,0,1,0;");
    // Program select in the same frame as the number
    xact("16,0,2,64,3;", "16,0,2,64,3;");
    cmp_val(32'h0000_0003, active_prog);
    xact("3,1,2;", "3,1,2,3,1;");
    xact("16,0,1,0;", "16,0,1,0;");
    xact("16,0,3,32,5,4;", "16,0,3,32,5,4;");
    xact("3,1,2;", "3,1,2,5,4;");
    xact("16,0,1,0;", "16,0,1,0;");
    // Level bits and edge bits of the control register
    xact("16,0,1,7;", "16,0,1,7;");
    cmp_val(32'h0000_0001, {31'h0, estop});
    cmp_val(32'h0000_0001, {31'h0, sleep});
    xact("16,0,1,7;", "16,0,1,7;");
    cmp_val(32'h0000_0001, {31'h0, estop});
    xact("16,0,1,2056;", "16,0,1,2056;");
    cmp_val(32'h0000_0000, {31'h0, estop});
    cmp_val(32'h0000_0000, {31'h0, sleep});
    // Full bank write and long read
    xact("16, 0, 20, 16, 1, 1, 150, 0, 5600, 0, 100, 5, 10, 20210608, 2, 114501, 0, 0, 0, 0, 0, 0, 0;",
         "16,0,20,16,1,1,150,0,5600,0,100,5,10,20210608,2,114501,0,0,0,0,0,0,0;");
    xact("3,3,17;", "3,3,17,150,0,5600,0,100,5,10,20210608,2,114501,0,0,0,0,0,0,0;");
    cmp_val(32'h0000_0001, cnt[5]);
    cmp_val(32'h0000_0001, cnt[4]);
    cmp_val(32'h0000_0001, cnt[3]);
    cmp_val(32'h0000_0002, cnt[2]);
    cmp_val(32'h0000_0003, cnt[1]);
    cmp_val(32'h0000_0002, cnt[0]);
    final_report();
  end
endmodule
`default_nettype wire
